// [ebtc_pkg.sv]
// shared constants, types and helpers of the eight bit timer counter
`default_nettype none
package ebtc_pkg;
    // register byte offsets on the bus
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFF_COUNT = 5'h00;
    localparam logic [4:0] OFF_OPTION = 5'h04;
    localparam logic [4:0] OFF_CAPSENSE = 5'h08;
    localparam logic [4:0] OFF_STATUS = 5'h0c;
    localparam logic [4:0] OFF_MASK = 5'h10;

    // option_control fields
    localparam int BIT_CLK_SRC = 5;
    localparam int BIT_EDGE = 4;
    localparam int BIT_BYPASS = 3;
    localparam int RATE_LSB = 0;
    localparam int RATE_W = 3;
    localparam logic [7:0] OPTION_IMPL = 8'h3f;

    // capsense_control, status and mask fields
    localparam int BIT_EXT_SRC = 0;
    localparam int BIT_OVF = 0;

    // reset values
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_OPTION = 8'h3f;
    localparam logic [7:0] RST_CAPSENSE = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;

    // timing: one instruction cycle is four clock phases
    localparam int PHASES_PER_INSTR = 4;
    localparam int INHIBIT_INSTR = 2;
    localparam int INHIBIT_CYCLES = INHIBIT_INSTR * PHASES_PER_INSTR;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // instruction phases, gray coded along the cycle
    typedef enum logic [1:0] {
        PH_ONE = 2'h0,
        PH_TWO = 2'h1,
        PH_THREE = 2'h3,
        PH_FOUR = 2'h2
    } ebtc_phase_e;

    // terminal prescale count: rate 0 gives 1:2, rate 7 gives 1:256
    function automatic logic [7:0] ebtc_ratio_mask(input logic [2:0] rate);
        ebtc_ratio_mask = 8'hff >> (3'h7 - rate);
    endfunction
endpackage
`default_nettype wire

// [ebtc_psc_if.sv]
// signals between the timer core and its prescaler
`timescale 1ns/1ns
`default_nettype none
interface ebtc_psc_if;
    logic srcEvent; // one source event to divide
    logic clear; // restart the division
    logic [2:0] rate; // division rate field
    logic tick; // divided output event
    modport ctrl (output srcEvent, output clear, output rate, input tick);
    modport psc (input srcEvent, input clear, input rate, output tick);
endinterface
`default_nettype wire

// [ebtc_edge_sync.sv]
// two flop synchronisers with rise and fall detection
`timescale 1ns/1ns
`default_nettype none
module ebtc_edge_sync #(
    parameter int W = 2
) (
    input wire logic clk_sys, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic [W-1:0] din, // asynchronous inputs
    output logic [W-1:0] rise, // one cycle pulse on low to high
    output logic [W-1:0] fall // one cycle pulse on high to low
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    // synchroniser chain plus history for the edge compare
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // edges only look at settled stages
    assign rise = stage2 & ~stage3;
    assign fall = ~stage2 & stage3;
endmodule
`default_nettype wire

// [ebtc_prescaler.sv]
// programmable power of two prescaler
`timescale 1ns/1ns
`default_nettype none
module ebtc_prescaler
    import ebtc_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic nrst, // async reset, active low
    ebtc_psc_if.psc psc // events in, divided ticks out
);
    logic [7:0] cnt;
    logic [7:0] mask;

    assign mask = ebtc_ratio_mask(psc.rate);

    // hidden division count, cleared by a count write
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt <= 8'h00;
        end else if (psc.clear) begin
            cnt <= 8'h00;
        end else if (psc.srcEvent) begin
            cnt <= (cnt >= mask) ? 8'h00 : cnt + 8'h01;
        end
    end

    // last event of a division period passes on
    assign psc.tick = psc.srcEvent && !psc.clear && (cnt >= mask);

    a_clear_zeroes: assert property (@(posedge clk_sys) disable iff (!nrst)
        psc.clear |=> cnt == 8'h00)
        else $error("prescaler not cleared");
    a_tick_at_end: assert property (@(posedge clk_sys) disable iff (!nrst)
        psc.tick |=> cnt == 8'h00)
        else $error("prescaler did not restart after tick");
endmodule
`default_nettype wire

// [ebtc_top.sv]
// eight bit timer counter with prescaler and axi4-lite registers
//
// Behaviour
// - timer mode without prescaler counts once per instruction cycle
// - a count write blocks counting for two following instruction cycles
// - counter mode advances on selected edges of pin or capsense clock
// - clock source 1 and external select 0 count the pin
// - clock source 1 and external select 1 count the capsense clock
// - edge select picks rising or falling transition for both sources
// - clearing bypass puts the private prescaler into the count path
// - eight division ratios from 1:2 to 1:256 by rate field
// - bypass set counts every source event, ratio 1:1
// - prescaler count is hidden and cleared by every count write
// - wrap from ff to 00 sets overflow flag regardless of enable
// - overflow requests interrupt only when its enable bit is set
// - counter mode increments are sampled in phases two and four
// - sleep freezes the count, so no overflow can occur
// - overflow is offered as a gate source for the 16-bit timer
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ebtc_top
    import ebtc_pkg::*;
(
    input wire logic clk_sys, // system clock, 50 MHz
    input wire logic nrst, // async reset, active low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic extClockPin, // external count pin, async
    input wire logic capsenseOscClock, // capsense oscillator, async
    input wire logic sleepReq, // processor sleeping, same clock
    output logic irq, // level interrupt
    output logic timer1Gate // one cycle overflow pulse for gating
);
    // registers and state
    logic [7:0] timer0Count;
    logic [7:0] optionControl;
    logic [7:0] capsenseControl;
    logic [7:0] irqMask;
    logic overflowFlag;
    logic pending;
    logic [3:0] inhibitCnt;
    ebtc_phase_e phase;
    ebtc_phase_e next_phase;

    // bus holding state
    logic awHeld;
    logic wHeld;
    logic [ADDR_W-1:0] wAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;

    // derived signals
    logic wrFire;
    logic rdFire;
    logic countWr;
    logic statusRd;
    logic [31:0] rdWord;
    logic clkSrc;
    logic edgeSel;
    logic bypass;
    logic extSel;
    logic [1:0] syncRise;
    logic [1:0] syncFall;
    logic edgePulse;
    logic timerEvent;
    logic srcEvent;
    logic presOut;
    logic samplePhase;
    logic incr;
    logic overflow;

    ebtc_psc_if pscBus();

    // offsets that hold a register
    function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
        isMapped = (addr == OFF_COUNT) || (addr == OFF_OPTION) ||
            (addr == OFF_CAPSENSE) || (addr == OFF_STATUS) ||
            (addr == OFF_MASK);
    endfunction

    // ------ axi4-lite write side
    assign s_axi_awready = !awHeld;
    assign s_axi_wready = !wHeld;
    assign wrFire = awHeld && wHeld && !s_axi_bvalid;

    // address and data may arrive in either order
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            awHeld <= 1'b0;
            wAddr <= '0;
        end else if (s_axi_awvalid && !awHeld) begin
            awHeld <= 1'b1;
            wAddr <= s_axi_awaddr;
        end else if (wrFire) begin
            awHeld <= 1'b0;
        end
    end

    // write data holding
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wHeld <= 1'b0;
            wData <= 32'h00000000;
            wStrb <= 4'h0;
        end else if (s_axi_wvalid && !wHeld) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
        end else if (wrFire) begin
            wHeld <= 1'b0;
        end
    end

    // write response, error for unmapped offsets
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= isMapped(wAddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------ axi4-lite read side
    assign s_axi_arready = !s_axi_rvalid;
    assign rdFire = s_axi_arvalid && !s_axi_rvalid;
    assign statusRd = rdFire && (s_axi_araddr == OFF_STATUS);

    // read multiplexer, unused bits read as zero
    always_comb begin
        rdWord = 32'h00000000;
        unique case (s_axi_araddr)
            OFF_COUNT: rdWord[7:0] = timer0Count;
            OFF_OPTION: rdWord[7:0] = optionControl;
            OFF_CAPSENSE: rdWord[7:0] = capsenseControl;
            OFF_STATUS: rdWord[BIT_OVF] = overflowFlag;
            OFF_MASK: rdWord[7:0] = irqMask;
            default: rdWord = 32'h00000000;
        endcase
    end

    // read data register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (rdFire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdWord;
            s_axi_rresp <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------ configuration registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            optionControl <= RST_OPTION;
            capsenseControl <= RST_CAPSENSE;
            irqMask <= RST_MASK;
        end else if (wrFire && wStrb[0]) begin
            if (wAddr == OFF_OPTION) begin
                optionControl <= wData[7:0] & OPTION_IMPL;
            end
            if (wAddr == OFF_CAPSENSE) begin
                capsenseControl <= wData[7:0] & (8'h01 << BIT_EXT_SRC);
            end
            if (wAddr == OFF_MASK) begin
                irqMask <= wData[7:0] & (8'h01 << BIT_OVF);
            end
        end
    end

    assign clkSrc = optionControl[BIT_CLK_SRC];
    assign edgeSel = optionControl[BIT_EDGE];
    assign bypass = optionControl[BIT_BYPASS];
    assign extSel = capsenseControl[BIT_EXT_SRC];
    assign countWr = wrFire && wStrb[0] && (wAddr == OFF_COUNT);

    // ------ instruction phase sequencer
    always_comb begin
        unique case (phase)
            PH_ONE: next_phase = PH_TWO;
            PH_TWO: next_phase = PH_THREE;
            PH_THREE: next_phase = PH_FOUR;
            PH_FOUR: next_phase = PH_ONE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            phase <= PH_ONE;
        end else begin
            phase <= next_phase;
        end
    end

    // ------ count sources
    ebtc_edge_sync #(
        .W(2)
    ) u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .din({capsenseOscClock, extClockPin}),
        .rise(syncRise),
        .fall(syncFall)
    );

    // pick source and edge, frozen in sleep
    assign edgePulse = edgeSel ? syncFall[extSel]
        : syncRise[extSel];
    assign timerEvent = (phase == PH_FOUR);
    assign srcEvent = (clkSrc ? edgePulse : timerEvent) && !sleepReq;

    // ------ prescaler in or out of the path
    assign pscBus.srcEvent = srcEvent && !bypass;
    assign pscBus.clear = countWr;
    assign pscBus.rate = optionControl[RATE_LSB +: RATE_W];

    ebtc_prescaler u_psc (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .psc(pscBus)
    );

    assign presOut = bypass ? srcEvent : pscBus.tick;

    // prescaler output waits for the next sampling phase
    assign samplePhase = (phase == PH_TWO) || (phase == PH_FOUR);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pending <= 1'b0;
        end else if (countWr) begin
            pending <= 1'b0;
        end else if (presOut) begin
            pending <= 1'b1;
        end else if (samplePhase) begin
            pending <= 1'b0;
        end
    end

    // ------ write inhibit window
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            inhibitCnt <= 4'h0;
        end else if (countWr) begin
            inhibitCnt <= 4'(INHIBIT_CYCLES);
        end else if (inhibitCnt != 4'h0) begin
            inhibitCnt <= inhibitCnt - 4'h1;
        end
    end

    // ------ the count itself
    assign incr = pending && samplePhase && (inhibitCnt == 4'h0) &&
        !sleepReq;
    assign overflow = incr && (timer0Count == 8'hff) && !countWr;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            timer0Count <= RST_COUNT;
        end else if (countWr) begin
            timer0Count <= wData[7:0];
        end else if (incr) begin
            timer0Count <= timer0Count + 8'h01;
        end
    end

    // ------ overflow flag, cleared by a status read, set wins
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            overflowFlag <= 1'b0;
        end else if (overflow) begin
            overflowFlag <= 1'b1;
        end else if (statusRd) begin
            overflowFlag <= 1'b0;
        end
    end

    // gate pulse for the wide timer
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            timer1Gate <= 1'b0;
        end else begin
            timer1Gate <= overflow;
        end
    end

    assign irq = overflowFlag && irqMask[BIT_OVF];

    // ------ checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    a_write_inhibit: assert property (
        countWr |=> ($stable(timer0Count) || $past(countWr))[*8])
        else $error("count moved inside write inhibit");
    a_wrap_to_zero: assert property (
        overflow |=> timer0Count == 8'h00 && overflowFlag)
        else $error("wrap did not reach zero with flag");
    a_step_by_one: assert property (
        incr && !countWr |=> timer0Count == $past(timer0Count) + 8'h01)
        else $error("count did not step by one");
    a_flag_sticky: assert property (
        overflowFlag && !statusRd |=> overflowFlag)
        else $error("overflow flag dropped without a read");
    a_irq_enable: assert property (
        overflow && irqMask[BIT_OVF] && !(wrFire && wAddr == OFF_MASK)
        |=> irq)
        else $error("enabled overflow raised no interrupt");
    a_irq_masked: assert property (
        !irqMask[BIT_OVF] |-> !irq)
        else $error("masked overflow raised interrupt");
    a_sleep_freeze: assert property (
        sleepReq && !countWr |=> $stable(timer0Count))
        else $error("count moved in sleep");
    a_sample_phase: assert property (
        $changed(timer0Count) && !$past(countWr)
        |-> $past(phase) == PH_TWO || $past(phase) == PH_FOUR)
        else $error("increment outside phases two and four");
    a_timer_rate: assert property (
        phase == PH_FOUR && !clkSrc && bypass && !sleepReq && !countWr
        |=> pending)
        else $error("timer event lost");
    a_edge_falling: assert property (
        clkSrc && edgeSel && syncFall[extSel] && !sleepReq && bypass
        && !countWr |=> pending)
        else $error("falling edge not counted");
    a_gate_pulse: assert property (
        overflow |=> timer1Gate ##1 !timer1Gate || $past(overflow))
        else $error("gate pulse missing");
    a_bus_slverr: assert property (
        rdFire && !isMapped(s_axi_araddr) |=> s_axi_rresp == RESP_SLVERR)
        else $error("unmapped read not refused");

    c_overflow: cover property (overflow ##[1:20] statusRd);
    c_counter_mode: cover property (clkSrc && extSel && incr);
    c_prescaled: cover property (!bypass && pscBus.tick ##[1:4] incr);
    c_write_then_count: cover property (countWr ##[9:20] incr);
endmodule
`default_nettype wire

// [ebtc_src_model.sv]
// count source model: external count pin and capsense oscillator
`timescale 1ns/1ns
`default_nettype none
module ebtc_src_model (
    input wire logic clk_sys, // system clock
    input wire logic run, // both sources toggle while high
    input wire logic pinLevel, // pin level while stopped
    input wire logic [7:0] pinHalf, // pin half period in clocks
    input wire logic [7:0] oscHalf, // oscillator half period in clocks
    output logic extClockPin, // external count pin
    output logic capsenseOscClock // capsense oscillator clock
);
    logic [7:0] pinCnt;
    logic [7:0] oscCnt;

    // periods stay above two instruction cycles so no edge is absorbed
    always @(posedge clk_sys) begin
        if (!run) begin
            pinCnt <= 8'h00;
            oscCnt <= 8'h00;
            extClockPin <= pinLevel;
            capsenseOscClock <= 1'b0;
        end else begin
            pinCnt <= (pinCnt == pinHalf - 8'h01) ? 8'h00 : pinCnt + 8'h01;
            oscCnt <= (oscCnt == oscHalf - 8'h01) ? 8'h00 : oscCnt + 8'h01;
            if (pinCnt == pinHalf - 8'h01) extClockPin <= !extClockPin;
            if (oscCnt == oscHalf - 8'h01) begin
                capsenseOscClock <= !capsenseOscClock;
            end
        end
    end
endmodule
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the eight bit timer counter
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin \
    n_checks++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("Error t=%0t got %h exp %h", $time, g, e); \
    end \
end
module tb_top
    import ebtc_pkg::*;
;
    typedef struct {
        logic [7:0] opt;
        logic caps;
        logic run;
        int win;
        logic [7:0] delta;
    } ebtc_row_s;
    localparam int NROW = 7;
    // option, source select, sources on, window clocks, expected increments
    ebtc_row_s rows [NROW] = '{
        '{8'h08, 1'b0, 1'b0, 40, 8'h0a}, '{8'h00, 1'b0, 1'b0, 80, 8'h0a},
        '{8'h02, 1'b0, 1'b0, 160, 8'h05}, '{8'h07, 1'b0, 1'b0, 2048, 8'h02},
        '{8'h28, 1'b0, 1'b1, 144, 8'h06}, '{8'h38, 1'b1, 1'b1, 240, 8'h06},
        '{8'h20, 1'b0, 1'b1, 144, 8'h03}};
    logic clk_sys, nrst, sleepReq, irq, timer1Gate, srcRun, pinLevel;
    logic extClockPin, capsenseOscClock;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [7:0] va, vb, dv;
    int fails = 0, n_checks = 0, cyc = 0, t0;

    ebtc_top ebtc_top_i (.clk_sys(clk_sys), .nrst(nrst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .extClockPin(extClockPin),
        .capsenseOscClock(capsenseOscClock), .sleepReq(sleepReq),
        .irq(irq), .timer1Gate(timer1Gate));

    ebtc_src_model ebtc_src_model_i (.clk_sys(clk_sys), .run(srcRun),
        .pinLevel(pinLevel), .pinHalf(8'h0c), .oscHalf(8'h14),
        .extClockPin(extClockPin), .capsenseOscClock(capsenseOscClock));

    // 50 MHz clock and a free cycle count for spacing reads
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) cyc <= cyc + 1;

    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one write; readies and bvalid sampled at the settled negedge
    task automatic axiWrite(input logic [4:0] a, input logic [7:0] d,
            output logic [1:0] r);
        logic aT, wT, bT;
        int n;
        n = 0;
        bT = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!bT && n < 100) begin
            @(negedge clk_sys);
            aT = s_axi_awvalid && s_axi_awready === 1'b1;
            wT = s_axi_wvalid && s_axi_wready === 1'b1;
            bT = s_axi_bvalid === 1'b1;
            r = s_axi_bresp;
            @(posedge clk_sys);
            if (aT) s_axi_awvalid <= 1'b0;
            if (wT) s_axi_wvalid <= 1'b0;
            n++;
        end
        s_axi_bready <= 1'b0;
        @(posedge clk_sys); // one edge between calls keeps bready single-driven
        if (!bT) begin
            fails++;
            print_verdict();
        end
    endtask

    // one read; rvalid, data and response sampled at the settled negedge
    task automatic axiRead(input logic [4:0] a, output logic [7:0] d,
            output logic [1:0] r);
        logic aT, rT;
        int n;
        n = 0;
        rT = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!rT && n < 100) begin
            @(negedge clk_sys);
            aT = s_axi_arvalid && s_axi_arready === 1'b1;
            rT = s_axi_rvalid === 1'b1;
            d = s_axi_rdata[7:0];
            r = s_axi_rresp;
            @(posedge clk_sys);
            if (aT) s_axi_arvalid <= 1'b0;
            n++;
        end
        s_axi_rready <= 1'b0;
        @(posedge clk_sys); // one edge between calls keeps rready single-driven
        if (!rT) begin
            fails++;
            print_verdict();
        end
    endtask

    task automatic waitTo(input int t);
        while (cyc < t) @(posedge clk_sys);
    endtask

    // bounded wait for the interrupt or the overflow pulse
    task automatic waitSig(input bit useIrq);
        int n;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while ((useIrq ? irq : timer1Gate) !== 1'b1 && n < 200);
        @(posedge clk_sys);
        if (n >= 200) begin
            fails++;
            print_verdict();
        end
    endtask

    initial begin
        {nrst, sleepReq, srcRun, pinLevel, s_axi_awvalid} = 5'h00;
        {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h0;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        // reset values, unmapped place, unimplemented option bits
        axiRead(OFF_COUNT, va, rs);
        `CHK(va, RST_COUNT)
        axiRead(OFF_OPTION, va, rs);
        `CHK(va, RST_OPTION)
        axiRead(OFF_CAPSENSE, va, rs);
        `CHK(va, RST_CAPSENSE)
        axiRead(OFF_MASK, va, rs);
        `CHK(va, RST_MASK)
        axiRead(OFF_STATUS, va, rs);
        `CHK(va, 8'h00)
        axiRead(5'h14, va, rs);
        `CHK(rs, RESP_SLVERR)
        axiWrite(5'h14, 8'h55, rs);
        `CHK(rs, RESP_SLVERR)
        axiWrite(OFF_OPTION, 8'hff, rs);
        axiRead(OFF_OPTION, va, rs);
        `CHK(va, OPTION_IMPL)
        // rows: increments over a window that is whole source periods
        for (int i = 0; i < NROW; i++) begin
            srcRun <= rows[i].run;
            axiWrite(OFF_CAPSENSE, {7'h00, rows[i].caps}, rs);
            axiWrite(OFF_OPTION, rows[i].opt, rs);
            waitTo(cyc + 50);
            t0 = cyc;
            axiRead(OFF_COUNT, va, rs);
            waitTo(t0 + rows[i].win);
            axiRead(OFF_COUNT, vb, rs);
            dv = vb - va;
            `CHK(dv, rows[i].delta)
        end
        // single edges on a stopped pin, rising then falling selected
        srcRun <= 1'b0;
        axiWrite(OFF_CAPSENSE, 8'h00, rs);
        axiWrite(OFF_OPTION, 8'h28, rs);
        axiRead(OFF_COUNT, va, rs);
        pinLevel <= 1'b1;
        waitTo(cyc + 20);
        axiRead(OFF_COUNT, vb, rs);
        `CHK(vb, va + 8'h01)
        axiWrite(OFF_OPTION, 8'h38, rs);
        axiRead(OFF_COUNT, va, rs);
        pinLevel <= 1'b0;
        waitTo(cyc + 20);
        axiRead(OFF_COUNT, vb, rs);
        `CHK(vb, va + 8'h01)
        pinLevel <= 1'b1;
        waitTo(cyc + 20);
        axiRead(OFF_COUNT, va, rs);
        `CHK(va, vb)
        // count write holds the value through two instruction cycles
        axiWrite(OFF_OPTION, 8'h08, rs);
        axiWrite(OFF_COUNT, 8'h50, rs);
        axiRead(OFF_COUNT, va, rs);
        `CHK(va, 8'h50)
        axiRead(OFF_COUNT, va, rs);
        `CHK(va, 8'h50)
        // rewrites keep 1:256 from ever ticking
        axiWrite(OFF_OPTION, 8'h07, rs);
        axiWrite(OFF_COUNT, 8'h00, rs);
        waitTo(cyc + 900);
        axiWrite(OFF_COUNT, 8'h00, rs);
        waitTo(cyc + 900);
        axiRead(OFF_COUNT, va, rs);
        `CHK(va, 8'h00)
        // sleep freezes the count
        axiWrite(OFF_OPTION, 8'h08, rs);
        sleepReq <= 1'b1;
        waitTo(cyc + 4);
        axiRead(OFF_COUNT, va, rs);
        waitTo(cyc + 100);
        axiRead(OFF_COUNT, vb, rs);
        `CHK(vb, va)
        sleepReq <= 1'b0;
        // overflow with interrupt masked, then enabled
        axiWrite(OFF_COUNT, 8'hfc, rs);
        waitSig(1'b0);
        @(negedge clk_sys);
        `CHK(irq, 1'b0)
        @(posedge clk_sys);
        axiRead(OFF_STATUS, va, rs);
        `CHK(va, 8'h01)
        axiRead(OFF_STATUS, va, rs);
        `CHK(va, 8'h00)
        axiWrite(OFF_MASK, 8'h01, rs);
        axiWrite(OFF_COUNT, 8'hfe, rs);
        waitSig(1'b1);
        waitTo(cyc + 20);
        @(negedge clk_sys);
        `CHK(irq, 1'b1)
        @(posedge clk_sys);
        axiRead(OFF_STATUS, va, rs);
        `CHK(va, 8'h01)
        @(negedge clk_sys);
        `CHK(irq, 1'b0)
        @(posedge clk_sys);
        print_verdict();
    end
endmodule
`default_nettype wire
